// ===== axil_slave.sv
// AXI4-Lite slave front end: handshakes, decode of index, responses
`timescale 1ns/100ps
module axil_slave
	import switch_cfg_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// write channels
	input  wire logic [AXI_AW-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// read channels
	input  wire logic [AXI_AW-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// register side
	regbus_if.bus                  rb
);
	typedef struct packed {
		logic              awf;
		logic              wf;
		logic [AXI_AW-1:0] awa;
		logic [31:0]       wd;
		logic [3:0]        ws;
		logic              awready;
		logic              wready;
		logic [1:0]        bresp;
		logic              bvalid;
		logic              arf;
		logic [AXI_AW-1:0] ara;
		logic              arready;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              rvalid;
	} axs_t;

	axs_t s;
	axs_t next_s;

	// index is only valid for the low 1 KiB; anything above is unmapped
	function automatic logic in_map(input logic [AXI_AW-1:0] a);
		return a[AXI_AW-1:10] == '0;
	endfunction

	always_comb
	begin
		next_s = s;
		rb.wr_stb = 1'b0;
		rb.wr_idx = s.awa[9:2];
		rb.wr_data = s.wd;
		rb.wr_strb = s.ws;
		rb.rd_idx = s.ara[9:2];
		if (awvalid && s.awready)
		begin
			next_s.awf = 1'b1;
			next_s.awa = awaddr;
		end
		if (wvalid && s.wready)
		begin
			next_s.wf = 1'b1;
			next_s.wd = wdata;
			next_s.ws = wstrb;
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		// commit only once both halves are held and the last answer left
		if (s.awf && s.wf && !s.bvalid)
		begin
			rb.wr_stb = in_map(s.awa);
			next_s.awf = 1'b0;
			next_s.wf = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = (in_map(s.awa) && rb.wr_hit) ? RESP_OKAY
				: RESP_SLVERR;
		end
		next_s.awready = !next_s.awf && !next_s.bvalid;
		next_s.wready = !next_s.wf && !next_s.bvalid;
		if (arvalid && s.arready)
		begin
			next_s.arf = 1'b1;
			next_s.ara = araddr;
		end
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		if (s.arf && !s.rvalid)
		begin
			next_s.arf = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = (in_map(s.ara) && rb.rd_hit) ? rb.rd_data
				: 32'h0000_0000;
			next_s.rresp = (in_map(s.ara) && rb.rd_hit) ? RESP_OKAY
				: RESP_SLVERR;
		end
		next_s.arready = !next_s.arf && !next_s.rvalid;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bresp = s.bresp;
	assign bvalid = s.bvalid;
	assign arready = s.arready;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign rvalid = s.rvalid;
endmodule

// ===== link_far_end.sv
// far end of the external links: credit answers and symbol traffic
`timescale 1ns/100ps
module link_far_end
(
	// clock and reset
	input wire logic       core_clk,
	input wire logic       sys_rst,
	// controls from the block; slow comes from the bench
	input wire logic [7:0] link_enable,
	input wire logic [7:0] credit_greeting_token,
	input wire logic [7:0] tx_sym_ok,
	input wire logic       slow,
	// events to the block
	output logic [7:0]     credit_issue_evt,
	output logic [7:0]     credit_recv_evt,
	output logic [7:0]     tx_sym_sent,
	output logic [7:0]     tx_tok_end
);
	logic [7:0][3:0] wait_cnt;
	logic [7:0][1:0] sym_cnt;
	logic [7:0]      en_q;
	always @(posedge core_clk)
	begin
		en_q <= sys_rst ? 8'h00 : link_enable;
		credit_issue_evt <= link_enable & ~en_q;
		for (int k = 0; k < 8; k++)
		begin
			credit_recv_evt[k] <= wait_cnt[k] == 4'h1;
			if (sys_rst)
				wait_cnt[k] <= 4'h0;
			else if (credit_greeting_token[k])
				wait_cnt[k] <= slow ? 4'hC : 4'h2;
			else if (wait_cnt[k] != 4'h0)
				wait_cnt[k] <= wait_cnt[k] - 4'h1;
			// send only when allowed; never two sends on adjacent edges
			tx_sym_sent[k] <= !sys_rst && tx_sym_ok[k] && !tx_sym_sent[k];
			tx_tok_end[k] <= sym_cnt[k] == 2'h3;
			if (sys_rst)
				sym_cnt[k] <= 2'h0;
			else if (tx_sym_sent[k])
				sym_cnt[k] <= sym_cnt[k] + 2'h1;
		end
	end
endmodule

// ===== regbus_if.sv
// register access strobes between the bus slave and the register file
`timescale 1ns/100ps
interface regbus_if;
	logic        wr_stb;
	logic [7:0]  wr_idx;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_hit;
	logic [7:0]  rd_idx;
	logic [31:0] rd_data;
	logic        rd_hit;
	modport bus (output wr_stb, wr_idx, wr_data, wr_strb, rd_idx,
		input wr_hit, rd_data, rd_hit);
	modport regs (input wr_stb, wr_idx, wr_data, wr_strb, rd_idx,
		output wr_hit, rd_data, rd_hit);
endinterface

// ===== switch_cfg_checker.sv
// port assertions for the switch route and link configuration block
`timescale 1ns/100ps
module switch_cfg_checker
	import switch_cfg_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// register bus
	input wire logic        awready,
	input wire logic        wready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        bvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	// link controls
	input wire logic [7:0]  link_enable,
	input wire logic [7:0]  link_wide,
	input wire logic [7:0]  credit_greeting_token,
	input wire logic [7:0]  link_rx_reset,
	input wire logic [7:0]  tx_sym_sent,
	input wire logic [7:0]  tx_sym_ok,
	// route lookup
	input wire logic        route_req,
	input wire logic        route_valid,
	input wire logic [3:0]  route_dim,
	input wire logic [3:0]  route_dir,
	input wire logic        route_lower,
	input wire logic        route_local,
	input wire logic        route_static
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	sequence ar_taken;
		arvalid && arready;
	endsequence
	sequence wr_answer;
		$rose(bvalid);
	endsequence
	read_answer_a: assert property (ar_taken |-> ##2 rvalid)
		else $error("read answer late");
	write_busy_a: assert property (bvalid |-> !awready && !wready)
		else $error("write channel open during response");
	slverr_zero_a: assert property (rvalid && rresp == RESP_SLVERR
		|-> rdata == 32'h0000_0000) else $error("error read not zero");
	greet_pulse_a: assert property (credit_greeting_token != 8'h00
		|-> wr_answer ##1 credit_greeting_token == 8'h00)
		else $error("greeting pulse wrong");
	rx_reset_a: assert property (link_rx_reset != 8'h00
		|-> wr_answer ##1 link_rx_reset == 8'h00)
		else $error("receiver reset pulse wrong");
	ctl_write_a: assert property ($changed({link_enable, link_wide})
		|-> wr_answer) else $error("link control moved without write");
	sym_gap_a: assert property (tx_sym_sent != 8'h00
		|=> (tx_sym_ok & $past(tx_sym_sent)) == 8'h00)
		else $error("no idle gap after symbol");
	route_answer_a: assert property (route_req |=> route_valid)
		else $error("route answer missing");
	route_pulse_a: assert property (route_valid |-> $past(route_req))
		else $error("route answer without request");
	upper_dim_a: assert property (route_valid && !route_static
		&& !route_local && !route_lower |-> route_dim[3])
		else $error("upper dimension below eight");
	lower_dim_a: assert property (route_valid && route_lower
		&& !route_static |-> !route_dim[3] && route_dir == 4'h0)
		else $error("lower route malformed");
endmodule

bind switch_link_route_config switch_cfg_checker chk (.*);

// ===== switch_cfg_pkg.sv
// shared register map, field layout and bus constants of the switch config
package switch_cfg_pkg;
	localparam int AXI_AW = 12;
	localparam int NLINK = 8;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_NODE_ID = 8'h05;
	localparam logic [7:0] IDX_DIR_UPPER = 8'h0D;
	localparam logic [7:0] IDX_RSV_A = 8'h10;
	localparam logic [7:0] IDX_RSV_B = 8'h11;
	localparam logic [7:0] IDX_DBG_SRC = 8'h1F;
	localparam logic [7:0] IDX_LINK_STAT = 8'h20;
	localparam logic [7:0] IDX_PROCESSOR_SIDE_LINK_STAT = 8'h40;
	localparam logic [7:0] IDX_EXT_CFG = 8'h80;
	localparam logic [7:0] IDX_STATIC = 8'hA0;
	// field positions
	localparam int F_TARGET = 24;
	localparam int F_DEST = 16;
	localparam int F_DIR = 8;
	localparam int F_NET = 4;
	localparam int F_JUNK = 2;
	localparam int F_DST_BUSY = 1;
	localparam int F_SRC_BUSY = 0;
	localparam int F_EN = 31;
	localparam int F_WIDE = 30;
	localparam int F_ERR = 27;
	localparam int F_ISSUED = 26;
	localparam int F_CREDIT = 25;
	localparam int F_CREDIT_GREETING_TOKEN = 24;
	localparam int F_RXRST = 23;
	localparam int F_SYM_GAP = 11;
	localparam int F_TOK_GAP = 0;
	localparam int F_SF_EN = 31;
	localparam int F_CHANEND = 0;
	// reset values
	localparam logic [31:0] RST_DIR_UPPER = 32'h0000_0000;
	localparam logic [15:0] RST_NODE_ID = 16'h0000;
	localparam logic [10:0] RST_GAP = 11'h000;
	// static register n controls external link C,D,A,B,G,H,E,F (A = 0)
	localparam logic [7:0][2:0] STATIC_LINK_MAP =
		{3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h2};
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== switch_link_route_config.sv
// switch node routing table, link status/config registers and tx pacing
`timescale 1ns/100ps
module switch_link_route_config
	import switch_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	// AXI4-Lite register bus
	input  wire logic [AXI_AW-1:0]    awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [AXI_AW-1:0]    araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	// switch-side link status
	input  wire logic [7:0][1:0]      ls_target,
	input  wire logic [7:0][7:0]      ls_dest,
	input  wire logic [7:0]           ls_junk,
	input  wire logic [7:0]           ls_dst_busy,
	input  wire logic [7:0]           ls_src_busy,
	// processor-side link status
	input  wire logic [7:0][1:0]      pl_target,
	input  wire logic [7:0][7:0]      pl_dest,
	input  wire logic [7:0]           pl_junk,
	input  wire logic [7:0]           pl_dst_busy,
	input  wire logic [7:0]           pl_src_busy,
	// debug events
	input  wire logic                 debug_evt,
	input  wire logic [7:0]           debug_src,
	// external link events
	input  wire logic [7:0]           rx_fault,
	input  wire logic [7:0]           credit_issue_evt,
	input  wire logic [7:0]           credit_recv_evt,
	input  wire logic [7:0]           tx_sym_sent,
	input  wire logic [7:0]           tx_tok_end,
	// external link controls
	output logic [7:0]                link_enable,
	output logic [7:0]                link_wide,
	output logic [7:0]                credit_greeting_token,
	output logic [7:0]                link_rx_reset,
	output logic [7:0]                tx_sym_ok,
	// route lookup request
	input  wire logic                 route_req,
	input  wire logic [15:0]          route_dst_id,
	input  wire logic [2:0]           route_link,
	// route lookup answer and reserved register bits
	output logic                      route_valid,
	output logic [3:0]                route_dir,
	output logic [3:0]                route_dim,
	output logic                      route_lower,
	output logic                      route_local,
	output logic                      route_static,
	output logic [4:0]                route_chanend,
	output logic [1:0]                rsv_a_bits,
	output logic [1:0]                rsv_b_bits
);
	typedef struct packed {
		logic [31:0]       dir_upper;
		logic [15:0]       node_id;
		logic [1:0]        rsv_a;
		logic [1:0]        rsv_b;
		logic [7:0]        dbg_src;
		logic [7:0][3:0]   ls_dir;
		logic [7:0][1:0]   ls_net;
		logic [7:0][1:0]   pl_net;
		logic [7:0]        xl_en;
		logic [7:0]        xl_wide;
		logic [7:0]        xl_err;
		logic [7:0]        xl_issued;
		logic [7:0]        xl_credit;
		logic [7:0]        xl_credit_greeting_token;
		logic [7:0]        xl_rxrst;
		logic [7:0][10:0]  sym_gap;
		logic [7:0][10:0]  tok_gap;
		logic [7:0][11:0]  gap_cnt;
		logic [7:0]        tx_ok;
		logic [7:0]        sf_en;
		logic [7:0][4:0]   sf_ce;
		logic              r_valid;
		logic [3:0]        r_dir;
		logic [3:0]        r_dim;
		logic              r_lower;
		logic              r_local;
		logic              r_static;
		logic [4:0]        r_chanend;
	} cfg_t;

	cfg_t c;
	cfg_t next_c;
	regbus_if rb ();

	axil_slave u_bus (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.awaddr   (awaddr),
		.awvalid  (awvalid),
		.awready  (awready),
		.wdata    (wdata),
		.wstrb    (wstrb),
		.wvalid   (wvalid),
		.wready   (wready),
		.bresp    (bresp),
		.bvalid   (bvalid),
		.bready   (bready),
		.araddr   (araddr),
		.arvalid  (arvalid),
		.arready  (arready),
		.rdata    (rdata),
		.rresp    (rresp),
		.rvalid   (rvalid),
		.rready   (rready),
		.rb       (rb.bus)
	);

	// one of eight consecutive indices starting at base
	function automatic logic in_group(input logic [7:0] idx,
		input logic [7:0] base);
		return idx[7:3] == base[7:3];
	endfunction

	// byte-lane merge of a write into the old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	// position of the most significant set bit of an 8-bit field
	function automatic logic [2:0] top_bit(input logic [7:0] v);
		logic [2:0] p;
		p = 3'h0;
		for (int i = 0; i < 8; i++)
			if (v[i])
				p = 3'(i);
		return p;
	endfunction

	// read-only status bits are assembled here, reserved bits stay zero
	function automatic logic [31:0] status_word(input logic [1:0] tgt,
		input logic [7:0] dst, input logic junk, input logic db,
		input logic sb);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[F_TARGET +: 2] = tgt;
		w[F_DEST +: 8] = dst;
		w[F_JUNK] = junk;
		w[F_DST_BUSY] = db;
		w[F_SRC_BUSY] = sb;
		return w;
	endfunction

	logic [2:0]  lane_w;
	logic [2:0]  lane_r;
	logic [31:0] old_w;
	logic [31:0] m;
	logic [15:0] diff;
	logic [2:0]  sf_reg;

	assign lane_w = rb.wr_idx[2:0];
	assign lane_r = rb.rd_idx[2:0];

	// read mux; unmapped indices answer with an error response
	always_comb
	begin
		rb.rd_hit = 1'b1;
		rb.rd_data = 32'h0000_0000;
		if (rb.rd_idx == IDX_DIR_UPPER)
			rb.rd_data = c.dir_upper;
		else if (rb.rd_idx == IDX_NODE_ID)
			rb.rd_data[15:0] = c.node_id;
		else if (rb.rd_idx == IDX_RSV_A)
			rb.rd_data[1:0] = c.rsv_a;
		else if (rb.rd_idx == IDX_RSV_B)
			rb.rd_data[1:0] = c.rsv_b;
		else if (rb.rd_idx == IDX_DBG_SRC)
			rb.rd_data[7:0] = c.dbg_src;
		else if (in_group(rb.rd_idx, IDX_LINK_STAT))
		begin
			rb.rd_data = status_word(ls_target[lane_r], ls_dest[lane_r],
				ls_junk[lane_r], ls_dst_busy[lane_r], ls_src_busy[lane_r]);
			rb.rd_data[F_DIR +: 4] = c.ls_dir[lane_r];
			rb.rd_data[F_NET +: 2] = c.ls_net[lane_r];
		end
		else if (in_group(rb.rd_idx, IDX_PROCESSOR_SIDE_LINK_STAT))
		begin
			rb.rd_data = status_word(pl_target[lane_r], pl_dest[lane_r],
				pl_junk[lane_r], pl_dst_busy[lane_r], pl_src_busy[lane_r]);
			rb.rd_data[F_NET +: 2] = c.pl_net[lane_r];
		end
		else if (in_group(rb.rd_idx, IDX_EXT_CFG))
		begin
			// greeting and receiver reset bits are write-only, read zero
			rb.rd_data[F_EN] = c.xl_en[lane_r];
			rb.rd_data[F_WIDE] = c.xl_wide[lane_r];
			rb.rd_data[F_ERR] = c.xl_err[lane_r];
			rb.rd_data[F_ISSUED] = c.xl_issued[lane_r];
			rb.rd_data[F_CREDIT] = c.xl_credit[lane_r];
			rb.rd_data[F_SYM_GAP +: 11] = c.sym_gap[lane_r];
			rb.rd_data[F_TOK_GAP +: 11] = c.tok_gap[lane_r];
		end
		else if (in_group(rb.rd_idx, IDX_STATIC))
		begin
			rb.rd_data[F_SF_EN] = c.sf_en[lane_r];
			rb.rd_data[F_CHANEND +: 5] = c.sf_ce[lane_r];
		end
		else
			rb.rd_hit = 1'b0;
	end

	// write decode; only writable fields are stored, the rest is dropped
	always_comb
	begin
		next_c = c;
		rb.wr_hit = 1'b1;
		old_w = 32'h0000_0000;
		m = 32'h0000_0000;
		next_c.xl_credit_greeting_token = 8'h00;
		next_c.xl_rxrst = 8'h00;
		if (rb.wr_idx == IDX_DIR_UPPER)
			old_w = c.dir_upper;
		else if (rb.wr_idx == IDX_NODE_ID)
			old_w[15:0] = c.node_id;
		else if (rb.wr_idx == IDX_RSV_A)
			old_w[1:0] = c.rsv_a;
		else if (rb.wr_idx == IDX_RSV_B)
			old_w[1:0] = c.rsv_b;
		else if (in_group(rb.wr_idx, IDX_LINK_STAT))
		begin
			old_w[F_DIR +: 4] = c.ls_dir[lane_w];
			old_w[F_NET +: 2] = c.ls_net[lane_w];
		end
		else if (in_group(rb.wr_idx, IDX_PROCESSOR_SIDE_LINK_STAT))
			old_w[F_NET +: 2] = c.pl_net[lane_w];
		else if (in_group(rb.wr_idx, IDX_EXT_CFG))
		begin
			old_w[F_EN] = c.xl_en[lane_w];
			old_w[F_WIDE] = c.xl_wide[lane_w];
			old_w[F_SYM_GAP +: 11] = c.sym_gap[lane_w];
			old_w[F_TOK_GAP +: 11] = c.tok_gap[lane_w];
		end
		else if (in_group(rb.wr_idx, IDX_STATIC))
		begin
			old_w[F_SF_EN] = c.sf_en[lane_w];
			old_w[F_CHANEND +: 5] = c.sf_ce[lane_w];
		end
		else if (rb.wr_idx != IDX_DBG_SRC)
			rb.wr_hit = 1'b0;
		m = merge(old_w, rb.wr_data, rb.wr_strb);
		if (rb.wr_stb)
		begin
			if (rb.wr_idx == IDX_DIR_UPPER)
				next_c.dir_upper = m;
			else if (rb.wr_idx == IDX_NODE_ID)
				next_c.node_id = m[15:0];
			else if (rb.wr_idx == IDX_RSV_A)
				next_c.rsv_a = m[1:0];
			else if (rb.wr_idx == IDX_RSV_B)
				next_c.rsv_b = m[1:0];
			else if (in_group(rb.wr_idx, IDX_LINK_STAT))
			begin
				next_c.ls_dir[lane_w] = m[F_DIR +: 4];
				next_c.ls_net[lane_w] = m[F_NET +: 2];
			end
			else if (in_group(rb.wr_idx, IDX_PROCESSOR_SIDE_LINK_STAT))
				next_c.pl_net[lane_w] = m[F_NET +: 2];
			else if (in_group(rb.wr_idx, IDX_EXT_CFG))
			begin
				next_c.xl_en[lane_w] = m[F_EN];
				next_c.xl_wide[lane_w] = m[F_WIDE];
				next_c.sym_gap[lane_w] = m[F_SYM_GAP +: 11];
				next_c.tok_gap[lane_w] = m[F_TOK_GAP +: 11];
				if (rb.wr_strb[3])
				begin
					next_c.xl_credit_greeting_token[lane_w] = rb.wr_data[F_CREDIT_GREETING_TOKEN];
				end
				if (rb.wr_strb[2])
					next_c.xl_rxrst[lane_w] = rb.wr_data[F_RXRST];
			end
			else if (in_group(rb.wr_idx, IDX_STATIC))
			begin
				next_c.sf_en[lane_w] = m[F_SF_EN];
				next_c.sf_ce[lane_w] = m[F_CHANEND +: 5];
			end
		end
		if (debug_evt)
			next_c.dbg_src = debug_src;
		// clears come first so that an event in the same cycle wins
		for (int i = 0; i < NLINK; i++)
		begin
			if (next_c.xl_rxrst[i])
				next_c.xl_err[i] = 1'b0;
			if (next_c.xl_credit_greeting_token[i])
				next_c.xl_credit[i] = 1'b0;
			if (!next_c.xl_en[i])
				next_c.xl_issued[i] = 1'b0;
			if (rx_fault[i])
				next_c.xl_err[i] = 1'b1;
			if (credit_issue_evt[i])
				next_c.xl_issued[i] = 1'b1;
			if (credit_recv_evt[i])
				next_c.xl_credit[i] = 1'b1;
			// count holds gap+1 idle clocks after each sent symbol
			if (tx_sym_sent[i])
				next_c.gap_cnt[i] = tx_tok_end[i]
					? {1'b0, c.tok_gap[i]} + 12'h001
					: {1'b0, c.sym_gap[i]} + 12'h001;
			else if (c.gap_cnt[i] != 12'h000)
				next_c.gap_cnt[i] = c.gap_cnt[i] - 12'h001;
			next_c.tx_ok[i] = next_c.xl_en[i]
				&& next_c.gap_cnt[i] == 12'h000;
		end
		// route lookup: static forwarding first, then local, then tables
		diff = route_dst_id ^ c.node_id;
		sf_reg = 3'h0;
		for (int j = 0; j < NLINK; j++)
			if (STATIC_LINK_MAP[j] == route_link)
				sf_reg = 3'(j);
		next_c.r_valid = route_req;
		if (route_req)
		begin
			next_c.r_static = 1'b0;
			next_c.r_local = 1'b0;
			next_c.r_lower = 1'b0;
			next_c.r_dir = 4'h0;
			next_c.r_dim = 4'h0;
			next_c.r_chanend = 5'h00;
			if (c.sf_en[sf_reg])
			begin
				next_c.r_static = 1'b1;
				next_c.r_chanend = c.sf_ce[sf_reg];
			end
			else if (diff == 16'h0000)
				next_c.r_local = 1'b1;
			else if (diff[15:8] != 8'h00)
			begin
				next_c.r_dim = {1'b1, top_bit(diff[15:8])};
				next_c.r_dir = c.dir_upper[top_bit(diff[15:8])*4 +: 4];
			end
			else
			begin
				// lower dimensions are resolved by the lower table elsewhere
				next_c.r_lower = 1'b1;
				next_c.r_dim = {1'b0, top_bit(diff[7:0])};
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			c <= '0;
			c.dir_upper <= RST_DIR_UPPER;
			c.node_id <= RST_NODE_ID;
		end
		else
			c <= next_c;
	end

	assign link_enable = c.xl_en;
	assign link_wide = c.xl_wide;
	assign credit_greeting_token = c.xl_credit_greeting_token;
	assign link_rx_reset = c.xl_rxrst;
	assign tx_sym_ok = c.tx_ok;
	assign route_valid = c.r_valid;
	assign route_dir = c.r_dir;
	assign route_dim = c.r_dim;
	assign route_lower = c.r_lower;
	assign route_local = c.r_local;
	assign route_static = c.r_static;
	assign route_chanend = c.r_chanend;
	assign rsv_a_bits = c.rsv_a;
	assign rsv_b_bits = c.rsv_b;
endmodule

// ===== testbench.sv
// self-checking bench for the switch route and link configuration block
`timescale 1ns/100ps
module testbench
	import switch_cfg_pkg::*;
;
	logic            core_clk = 1'h0, sys_rst = 1'h1, slow = 1'h0;
	logic [11:0]     awaddr = '0, araddr = '0;
	logic            awvalid = '0, wvalid = '0, bready = '0;
	logic            arvalid = '0, rready = '0, debug_evt = '0;
	logic [31:0]     wdata = '0, rdata, rd_q;
	logic [3:0]      wstrb = 4'hF;
	logic            awready, wready, bvalid, arready, rvalid;
	logic [1:0]      bresp, rresp, rsp, rsv_a_bits, rsv_b_bits;
	logic [7:0][1:0] ls_target = '0, pl_target = '0;
	logic [7:0][7:0] ls_dest = '0, pl_dest = '0;
	logic [7:0]      ls_junk = '0, ls_dst_busy = '0, ls_src_busy = '0;
	logic [7:0]      pl_junk = '0, pl_dst_busy = '0, pl_src_busy = '0;
	logic [7:0]      debug_src = '0, rx_fault = '0, link_enable, link_wide;
	logic [7:0]      credit_issue_evt, credit_recv_evt, tx_sym_sent;
	logic [7:0]      tx_tok_end, credit_greeting_token, link_rx_reset;
	logic [7:0]      tx_sym_ok;
	logic            route_req = '0, route_valid, route_lower, route_local;
	logic            route_static;
	logic [15:0]     route_dst_id = '0;
	logic [2:0]      route_link = '0;
	logic [3:0]      route_dir, route_dim;
	logic [4:0]      route_chanend;
	int              n_mismatch = 0, checked = 0, gap_cnt = 1000;
	logic            last_end = 1'h0;

	switch_link_route_config DUT (.*);
	link_far_end far_end (.*);

	always #10 core_clk = ~core_clk;

	task automatic fail(input string m);
		n_mismatch++;
		$display("Error %0t %s", $time, m);
	endtask
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
			fail($sformatf("got %h expected %h", g, e));
	endtask
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		checked++;
		if (g !== e)
			fail($sformatf("response %h expected %h", g, e));
	endtask
	task automatic finish_test();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		int n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
			n++;
		end
		while (bvalid !== 1'h1 && n < 40);
		if (n >= 40)
			fail("write hang");
		rsp = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a);
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			if (arready)
				arvalid <= 1'h0;
			n++;
		end
		while (rvalid !== 1'h1 && n < 40);
		if (n >= 40)
			fail("read hang");
		rsp = rresp;
		rd_q = rdata;
		rready <= 1'h0;
	endtask
	task automatic route(input logic [15:0] x, input logic [2:0] l);
		@(posedge core_clk);
		route_req <= 1'h1;
		route_dst_id <= x;
		route_link <= l;
		@(posedge core_clk);
		route_req <= 1'h0;
		#1;
	endtask

	function automatic logic [31:0] exp_stat(input int n, input bit p,
		input logic [31:0] w);
		logic [2:0] f;
		f = p ? {pl_junk[n], pl_dst_busy[n], pl_src_busy[n]}
			: {ls_junk[n], ls_dst_busy[n], ls_src_busy[n]};
		return {6'h00, p ? pl_target[n] : ls_target[n],
			p ? pl_dest[n] : ls_dest[n], 4'h0, p ? 4'h0 : w[11:8],
			2'h0, w[5:4], 1'h0, f};
	endfunction
	function automatic logic [10:0] exp_route(input logic [15:0] x,
		input logic [15:0] id, input logic [31:0] dr);
		exp_route = 11'h200;
		for (int i = 0; i < 16; i++)
			if (x[i] ^ id[i])
				exp_route = i > 7 ? {3'h0, 4'(i), dr[4 * (i & 7) +: 4]}
					: {3'h1, 4'(i), 4'h0};
	endfunction

	// link 0 runs with symbol gap 3 and token gap 6
	always @(posedge core_clk)
	begin
		gap_cnt <= gap_cnt + 1;
		if (tx_sym_sent[0] === 1'h1)
		begin
			chk_word(32'(gap_cnt >= (last_end ? 8 : 5)), 32'h1);
			gap_cnt <= 1;
			last_end <= tx_tok_end[0];
		end
	end

	initial
	begin
		#1000000;
		fail("watchdog");
		finish_test();
	end

	initial
	begin
		logic [31:0] d, w;
		logic [21:0] g;
		logic [15:0] id, x;
		logic [10:0] e;
		logic [4:0]  c;
		logic        b;
		int          lm[8] = '{2, 3, 0, 1, 6, 7, 4, 5};
		d = $urandom(32'hDEA8);
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'h0;
		{ls_target, ls_dest, ls_junk, ls_dst_busy, ls_src_busy} <=
			104'({$urandom(), $urandom(), $urandom(), $urandom()});
		{pl_target, pl_dest, pl_junk, pl_dst_busy, pl_src_busy} <=
			104'({$urandom(), $urandom(), $urandom(), $urandom()});
		rd(12'h014); chk_word(rd_q, 32'h0);
		rd(12'h034); chk_word(rd_q, 32'h0);
		rd(12'h200); chk_word(rd_q, 32'h0);
		rd(12'h280); chk_word(rd_q, 32'h0);
		w = $urandom();
		wr(12'h034, w);
		wr(12'h034, ~w, 4'h3);
		w = {w[31:16], ~w[15:0]};
		rd(12'h034); chk_word(rd_q, w);
		d = $urandom();
		id = d[15:0];
		wr(12'h014, d);
		rd(12'h014); chk_word(rd_q, {16'h0, id});
		chk_resp(rsp, RESP_OKAY);
		for (int i = 0; i < 24; i++)
		begin
			x = i == 0 ? id : i == 1 ? id ^ 16'h1 : i == 2 ? id ^ 16'h8000
				: 16'($urandom());
			route(x, 3'($urandom()));
			e = exp_route(x, id, w);
			d = 32'({route_static, route_local, route_lower, route_dim,
				route_dir});
			chk_word(e[9] ? d[10:8] : d, e[9] ? e[10:8] : e);
		end
		for (int i = 0; i < 16; i++)
		begin
			d = $urandom();
			wr(12'(12'h080 + 12'h080 * (i / 8) + 4 * (i % 8)), d);
			rd(12'(12'h080 + 12'h080 * (i / 8) + 4 * (i % 8)));
			chk_word(rd_q, exp_stat(i % 8, i > 7, d));
		end
		for (int i = 0; i < 2; i++)
		begin
			d = $urandom();
			wr(12'(12'h040 + 4 * i), d);
			rd(12'(12'h040 + 4 * i)); chk_word(rd_q, {30'h0, d[1:0]});
			chk_word(32'(i ? rsv_b_bits : rsv_a_bits), 32'(d[1:0]));
		end
		debug_src <= 8'($urandom());
		debug_evt <= 1'h1;
		@(posedge core_clk);
		debug_evt <= 1'h0;
		wr(12'h07C, 32'hFFFF_FFFF);
		chk_resp(rsp, RESP_OKAY);
		rd(12'h07C); chk_word(rd_q, {24'h0, debug_src});
		for (int i = 0; i < 2; i++)
		begin
			wr(i ? 12'hC14 : 12'h048, $urandom());
			chk_resp(rsp, RESP_SLVERR);
			rd(i ? 12'hC14 : 12'h048); chk_resp(rsp, RESP_SLVERR);
			chk_word(rd_q, 32'h0);
		end
		for (int n = 0; n < 8; n++)
		begin
			slow <= 1'($urandom());
			b = 1'($urandom());
			g = n == 0 ? {11'h003, 11'h006}
				: {7'h00, 4'($urandom()), 7'h00, 4'($urandom())};
			wr(12'(12'h200 + 4 * n), {1'h1, b, 5'h00, 1'h1, 2'h0, g});
			repeat (20) @(posedge core_clk);
			rd(12'(12'h200 + 4 * n)); chk_word(rd_q, {2'h2 | b, 3'h0, 2'h3, 3'h0, g});
			chk_word(32'({link_enable[n], link_wide[n]}), 32'({1'h1, b}));
			rx_fault[n] <= 1'h1;
			@(posedge core_clk);
			rx_fault <= 8'h00;
			rd(12'(12'h200 + 4 * n)); chk_word(rd_q[27], 32'h1);
			wr(12'(12'h200 + 4 * n), {1'h1, b, 6'h00, 1'h1, 1'h0, g});
			rd(12'(12'h200 + 4 * n)); chk_word(rd_q, {2'h2 | b, 3'h0, 2'h3, 3'h0, g});
		end
		for (int j = 0; j < 8; j++)
		begin
			c = 5'($urandom());
			wr(12'(12'h280 + 4 * j), {1'h1, 26'h3FF_FFFF, c});
			rd(12'(12'h280 + 4 * j)); chk_word(rd_q, {1'h1, 26'h0, c});
			route(16'($urandom()), 3'(lm[j]));
			chk_word(32'({route_static, route_chanend}), 32'({1'h1, c}));
		end
		finish_test();
	end
endmodule
